//--- hw/dte_top.sv
// ds3 transmit overhead generation and error insertion with apb registers
//
// Function
// - parity_gen_enable overwrites p-bits even without frame generation
// - tx_idle_insert puts the idle pattern into the frame
// - m23 mode: c-bits zeroed unless frame_gen_disable or cbit_gen_disable set
// - manual febe: c41..c43 carry inverted manual_far_block_err
// - auto febe from received c-parity or framing errors
// - manual rdi: x1, x2 carry inverted manual_remote_defect
// - auto rdi from received alarm conditions
// - frame_gen_disable passes overhead; insertions may still overwrite
// - tx_alarm_indication puts alarm pattern into payload
// - c-parity errors only when enabled; continuous or single
// - febe errors only when enabled; continuous or single
// - p-parity errors only when enabled; continuous or single
// - framing_err_type picks f-bit, m-bit, sef or oomf error
// - framing errors only while framing_err_enable set
// - rising single_err_trigger inserts one error per enabled type
// - many toggles between opportunities give only one error
// - err_trigger_source_sel picks register bit or external input
// - control at 118h, insertion at 11Ah, 11Ch/11Eh reserved
module dte_top
   import dte_pkg::*;
(
   // clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // apb slave
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [13:0]      paddr,
   input  wire logic [31:0]      pwdata,
   input  wire logic [3:0]       pstrb,
   output logic      [31:0]      prdata,
   output logic                  pready,
   output logic                  pslverr,
   // payload in from upstream
   input  wire logic             in_valid,
   input  wire dte_pkg::dte_sym_t in_sym,
   // line side out
   output logic                  out_valid,
   output dte_pkg::dte_sym_t     out_sym,
   // receive side indications
   input  wire logic             rx_cpar_err,
   input  wire logic             rx_frm_err,
   input  wire logic             rx_alarm,
   // external error insert pin
   input  wire logic             ext_err_insert_input
);
   import dte_pkg::*;

   dte_tcr_t    tcr_ff;
   dte_teir_t   teir_ff;
   logic [15:0] mode_ff;
   logic [31:0] prdata_ff;
   logic        pready_ff;
   logic        pslverr_ff;
   logic        out_valid_ff;
   dte_sym_t    out_sym_ff;

   // apb decode
   logic [11:0] idx;
   logic        setup;
   logic        wr_done;
   logic [15:0] wmask;
   logic [31:0] nxt_prdata;
   logic        nxt_pslverr;
   logic [3:0]  pend_vec;

   assign idx     = paddr[13:2];
   assign setup   = psel && !penable;
   assign wr_done = psel && penable && pready_ff && pwrite;
   assign wmask   = {{8{pstrb[1]}}, {8{pstrb[0]}}};

   // register map decode
   always_comb begin
      nxt_prdata  = 32'h0000_0000;
      nxt_pslverr = 1'b0;
      unique case (idx)
         DTE_TCR_IDX:  nxt_prdata[15:0] = tcr_ff;
         DTE_TEIR_IDX: nxt_prdata[15:0] = teir_ff;
         DTE_MODE_IDX: nxt_prdata[15:0] = {4'h0, pend_vec, mode_ff[7:0]};
         DTE_RSV0_IDX: nxt_prdata = 32'h0000_0000;
         DTE_RSV1_IDX: nxt_prdata = 32'h0000_0000;
         default:      nxt_pslverr = 1'b1;
      endcase
   end

   // no wait state: answer in the cycle after setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff  <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
         pslverr_ff <= 1'b0;
      end else begin
         pready_ff <= setup;
         if (setup) begin
            prdata_ff  <= pwrite ? 32'h0000_0000 : nxt_prdata;
            pslverr_ff <= nxt_pslverr;
         end else if (!psel) begin
            pslverr_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tcr_ff  <= DTE_TCR_RST;
         teir_ff <= DTE_TEIR_RST;
         mode_ff <= DTE_MODE_RST;
      end else if (wr_done) begin
         if (idx == DTE_TCR_IDX) begin
            tcr_ff <= (tcr_ff & ~(wmask & DTE_TCR_MASK))
                    | (pwdata[15:0] & wmask & DTE_TCR_MASK);
         end
         if (idx == DTE_TEIR_IDX) begin
            teir_ff <= (teir_ff & ~(wmask & DTE_TEIR_MASK))
                     | (pwdata[15:0] & wmask & DTE_TEIR_MASK);
         end
         if (idx == DTE_MODE_IDX) begin
            mode_ff <= (mode_ff & ~(wmask & DTE_MODE_MASK))
                     | (pwdata[15:0] & wmask & DTE_MODE_MASK);
         end
      end
   end

   // external pin: three stages, accepted once the last two agree
   logic ext_s1_ff;
   logic ext_s2_ff;
   logic ext_s3_ff;
   logic ext_filt_ff;
   logic ext_prev_ff;
   logic single_err_trigger_prev_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_s1_ff   <= 1'b0;
         ext_s2_ff   <= 1'b0;
         ext_s3_ff   <= 1'b0;
         ext_filt_ff <= 1'b0;
      end else begin
         ext_s1_ff <= ext_err_insert_input;
         ext_s2_ff <= ext_s1_ff;
         ext_s3_ff <= ext_s2_ff;
         if (ext_s2_ff == ext_s3_ff) begin
            ext_filt_ff <= ext_s3_ff;
         end
      end
   end

   // both edge detectors always run so a source switch is clean
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_prev_ff  <= 1'b0;
         single_err_trigger_prev_ff <= 1'b0;
      end else begin
         ext_prev_ff  <= ext_filt_ff;
         single_err_trigger_prev_ff <= teir_ff.single_err_trigger;
      end
   end

   logic trig_reg;
   logic trig_ext;
   logic trig;
   assign trig_reg = teir_ff.single_err_trigger && !single_err_trigger_prev_ff;
   assign trig_ext = ext_filt_ff && !ext_prev_ff;
   assign trig = teir_ff.err_trigger_source_sel ? trig_ext : trig_reg;

   logic       frame_start;
   logic       arm_frm;
   logic       arm_p;
   logic       arm_c;
   logic       arm_fb;
   assign frame_start = in_valid && in_sym.sof;

   dte_err_arm u_arm_frm (
      .pclk        (pclk),
      .presetn     (presetn),
      .enable      (teir_ff.framing_err_enable),
      .continuous  (1'b0),
      .trigger     (trig),
      .frame_start (frame_start),
      .pending     (pend_vec[0]),
      .armed       (arm_frm)
   );
   dte_err_arm u_arm_p (
      .pclk        (pclk),
      .presetn     (presetn),
      .enable      (teir_ff.pbit_parity_err_enable),
      .continuous  (teir_ff.pbit_parity_err_continuous),
      .trigger     (trig),
      .frame_start (frame_start),
      .pending     (pend_vec[1]),
      .armed       (arm_p)
   );
   dte_err_arm u_arm_c (
      .pclk        (pclk),
      .presetn     (presetn),
      .enable      (teir_ff.cbit_parity_err_enable),
      .continuous  (teir_ff.cbit_parity_err_continuous),
      .trigger     (trig),
      .frame_start (frame_start),
      .pending     (pend_vec[2]),
      .armed       (arm_c)
   );
   dte_err_arm u_arm_fb (
      .pclk        (pclk),
      .presetn     (presetn),
      .enable      (teir_ff.far_block_err_enable),
      .continuous  (teir_ff.far_block_err_continuous),
      .trigger     (trig),
      .frame_start (frame_start),
      .pending     (pend_vec[3]),
      .armed       (arm_fb)
   );

   // frame position counters, parity and febe latches
   logic [4:0] f_cnt_ff;
   logic [1:0] m_cnt_ff;
   logic [1:0] pat_ff;
   logic       par_acc_ff;
   logic       par_ff;
   logic       err_acc_ff;
   logic       febe_ff;
   logic [4:0] f_cnt;
   logic [1:0] m_cnt;
   logic       gen;
   logic       m23;
   logic       d;
   logic       is_pay;

   assign f_cnt = in_sym.sof ? 5'h00 : f_cnt_ff;
   assign m_cnt = in_sym.sof ? 2'h0 : m_cnt_ff;
   assign gen   = !tcr_ff.frame_gen_disable;
   assign m23   = !mode_ff[0];
   assign is_pay = in_sym.pos == DTE_POS_PAY;

   // overhead generation then error insertion, one bit per valid
   always_comb begin
      d = in_sym.data;
      if (m23 && (in_sym.pos == DTE_POS_C || in_sym.pos == DTE_POS_CPAR
                  || in_sym.pos == DTE_POS_FEBE)) begin
         if (gen && !tcr_ff.cbit_gen_disable) begin
            d = 1'b0;
         end
      end else begin
         unique case (in_sym.pos)
            DTE_POS_PAY: begin
               if (tcr_ff.tx_alarm_indication) begin
                  d = ~pat_ff[0];
               end else if (tcr_ff.tx_idle_insert) begin
                  d = ~pat_ff[1];
               end
            end
            DTE_POS_F: begin
               // pass through when generation is off
               if (gen) begin
                  d = DTE_F_PATTERN[f_cnt[1:0]];
               end
               if (arm_frm && (teir_ff.framing_err_type == DTE_FE_SEF ||
                   (teir_ff.framing_err_type == DTE_FE_FBIT
                    && f_cnt == 5'h00))) begin
                  d = ~d;
               end
            end
            DTE_POS_M: begin
               if (gen) begin
                  d = DTE_M_PATTERN[m_cnt];
               end
               if (arm_frm && (teir_ff.framing_err_type == DTE_FE_OOMF ||
                   (teir_ff.framing_err_type == DTE_FE_MBIT
                    && m_cnt == 2'h0))) begin
                  d = ~d;
               end
            end
            DTE_POS_X: begin
               if (gen) begin
                  d = tcr_ff.auto_remote_defect_defeat
                    ? ~tcr_ff.manual_remote_defect : ~rx_alarm;
               end
            end
            DTE_POS_P: begin
               if (gen || tcr_ff.parity_gen_enable) begin
                  d = par_ff;
               end
               if (arm_p) begin
                  d = ~d;
               end
            end
            DTE_POS_CPAR: begin
               if (gen) begin
                  d = par_ff;
               end
               if (arm_c) begin
                  d = ~d;
               end
            end
            DTE_POS_FEBE: begin
               if (gen) begin
                  d = tcr_ff.auto_far_block_err_defeat
                    ? ~tcr_ff.manual_far_block_err : ~febe_ff;
               end
               if (arm_fb) begin
                  d = 1'b0;
               end
            end
            DTE_POS_C: begin
               d = in_sym.data;
            end
         endcase
      end
   end

   // counters advance only on valid bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         f_cnt_ff <= 5'h00;
         m_cnt_ff <= 2'h0;
         pat_ff   <= 2'h0;
      end else if (in_valid) begin
         f_cnt_ff <= (in_sym.pos == DTE_POS_F) ? f_cnt + 5'h01 : f_cnt;
         if (in_sym.pos == DTE_POS_M) begin
            m_cnt_ff <= (m_cnt == 2'h2) ? 2'h0 : m_cnt + 2'h1;
         end else begin
            m_cnt_ff <= m_cnt;
         end
         if (is_pay) begin
            pat_ff <= pat_ff + 2'h1;
         end
      end
   end

   // parity of the outgoing payload, used by the following frame
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         par_acc_ff <= 1'b0;
         par_ff     <= 1'b0;
      end else if (in_valid) begin
         if (in_sym.sof) begin
            par_ff     <= par_acc_ff;
            par_acc_ff <= is_pay && d;
         end else begin
            par_acc_ff <= par_acc_ff ^ (is_pay && d);
         end
      end
   end

   // receive errors in one frame flag febe in the next
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_acc_ff <= 1'b0;
         febe_ff    <= 1'b0;
      end else if (frame_start) begin
         febe_ff    <= err_acc_ff || rx_cpar_err || rx_frm_err;
         err_acc_ff <= 1'b0;
      end else if (rx_cpar_err || rx_frm_err) begin
         err_acc_ff <= 1'b1;
      end
   end

   // output register, one cycle of latency
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_valid_ff <= 1'b0;
         out_sym_ff   <= '0;
      end else begin
         out_valid_ff <= in_valid;
         if (in_valid) begin
            out_sym_ff <= '{sof: in_sym.sof, pos: in_sym.pos, data: d};
         end
      end
   end

   assign prdata    = prdata_ff;
   assign pready    = pready_ff;
   assign pslverr   = pslverr_ff;
   assign out_valid = out_valid_ff;
   assign out_sym   = out_sym_ff;

   // checks
   sequence s_apb_setup_rd;
      psel && !penable && !pwrite && idx == DTE_TCR_IDX;
   endsequence
   sequence s_apb_access;
      psel && penable && pready;
   endsequence

   property p_tcr_read;
      @(posedge pclk) disable iff (!presetn)
      s_apb_setup_rd ##1 s_apb_access |-> prdata == {16'h0000, tcr_ff};
   endproperty
   a_tcr_read: assert property (p_tcr_read)
      else $error("tcr read data wrong");

   property p_pbit_pass;
      @(posedge pclk) disable iff (!presetn)
      in_valid && in_sym.pos == DTE_POS_P && !gen
      && !tcr_ff.parity_gen_enable && !arm_p
      |=> out_valid && out_sym.data == $past(in_sym.data);
   endproperty
   a_pbit_pass: assert property (p_pbit_pass)
      else $error("p-bit not passed through");

   property p_c_zero;
      @(posedge pclk) disable iff (!presetn)
      in_valid && m23 && in_sym.pos == DTE_POS_C && gen
      && !tcr_ff.cbit_gen_disable |=> out_sym.data == 1'b0;
   endproperty
   a_c_zero: assert property (p_c_zero)
      else $error("m23 c-bit not zeroed");

   property p_febe_manual;
      @(posedge pclk) disable iff (!presetn)
      in_valid && !m23 && in_sym.pos == DTE_POS_FEBE && gen && !arm_fb
      && tcr_ff.auto_far_block_err_defeat
      |=> out_sym.data != $past(tcr_ff.manual_far_block_err);
   endproperty
   a_febe_manual: assert property (p_febe_manual)
      else $error("manual febe value wrong");

   property p_rdi_manual;
      @(posedge pclk) disable iff (!presetn)
      in_valid && in_sym.pos == DTE_POS_X && gen
      && tcr_ff.auto_remote_defect_defeat
      |=> out_sym.data != $past(tcr_ff.manual_remote_defect);
   endproperty
   a_rdi_manual: assert property (p_rdi_manual)
      else $error("manual rdi value wrong");

   // last payload bit out; payload bits are not adjacent on the line
   logic pay_last_ff;
   logic ais_run_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pay_last_ff <= 1'b0;
         ais_run_ff  <= 1'b0;
      end else if (in_valid && is_pay) begin
         pay_last_ff <= d;
         ais_run_ff  <= tcr_ff.tx_alarm_indication;
      end
   end

   property p_ais_alt;
      @(posedge pclk) disable iff (!presetn)
      in_valid && is_pay && tcr_ff.tx_alarm_indication && ais_run_ff
      |=> out_sym.data != $past(pay_last_ff);
   endproperty
   a_ais_alt: assert property (p_ais_alt)
      else $error("alarm pattern does not alternate");

   property p_no_frm_err;
      @(posedge pclk) disable iff (!presetn)
      in_valid && in_sym.pos == DTE_POS_F && !gen
      && !teir_ff.framing_err_enable
      |=> out_sym.data == $past(in_sym.data);
   endproperty
   a_no_frm_err: assert property (p_no_frm_err)
      else $error("framing error while disabled");

   property p_single_pend;
      @(posedge pclk) disable iff (!presetn)
      trig_reg && !teir_ff.err_trigger_source_sel && !frame_start
      && teir_ff.pbit_parity_err_enable
      && !teir_ff.pbit_parity_err_continuous
      ##1 teir_ff.pbit_parity_err_enable |-> pend_vec[1];
   endproperty
   a_single_pend: assert property (p_single_pend)
      else $error("register trigger not taken");
endmodule

//--- hw/dte_pkg.sv
// shared constants and types for the ds3 transmit overhead/error block
package dte_pkg;

   // register indices; byte address is four times the index
   localparam logic [11:0] DTE_MODE_IDX = 12'h0116;
   localparam logic [11:0] DTE_TCR_IDX  = 12'h0118;
   localparam logic [11:0] DTE_TEIR_IDX = 12'h011a;
   localparam logic [11:0] DTE_RSV0_IDX = 12'h011c;
   localparam logic [11:0] DTE_RSV1_IDX = 12'h011e;

   // reset values and writable bits
   localparam logic [15:0] DTE_TCR_RST   = 16'h0000;
   localparam logic [15:0] DTE_TEIR_RST  = 16'h0000;
   localparam logic [15:0] DTE_MODE_RST  = 16'h0000;
   localparam logic [15:0] DTE_TCR_MASK  = 16'h1c3f;
   localparam logic [15:0] DTE_TEIR_MASK = 16'h0f7f;
   localparam logic [15:0] DTE_MODE_MASK = 16'h0001;

   // overhead bit patterns, indexed by position count
   localparam logic [3:0] DTE_F_PATTERN = 4'h9;
   localparam logic [2:0] DTE_M_PATTERN = 3'h2;

   typedef struct packed {
      logic [2:0] rsv15;
      logic       parity_gen_enable;
      logic       tx_idle_insert;
      logic       cbit_gen_disable;
      logic [3:0] rsv9;
      logic       manual_far_block_err;
      logic       auto_far_block_err_defeat;
      logic       manual_remote_defect;
      logic       auto_remote_defect_defeat;
      logic       frame_gen_disable;
      logic       tx_alarm_indication;
   } dte_tcr_t;

   typedef struct packed {
      logic [3:0] rsv15;
      logic       cbit_parity_err_continuous;
      logic       cbit_parity_err_enable;
      logic       far_block_err_continuous;
      logic       far_block_err_enable;
      logic       rsv7;
      logic       pbit_parity_err_continuous;
      logic       pbit_parity_err_enable;
      logic [1:0] framing_err_type;
      logic       framing_err_enable;
      logic       single_err_trigger;
      logic       err_trigger_source_sel;
   } dte_teir_t;

   typedef enum logic [1:0] {
      DTE_FE_FBIT = 2'h0,
      DTE_FE_MBIT = 2'h1,
      DTE_FE_SEF  = 2'h2,
      DTE_FE_OOMF = 2'h3
   } dte_fe_t;

   // class of each bit position in the ds3 frame
   typedef enum logic [2:0] {
      DTE_POS_PAY  = 3'h0,
      DTE_POS_X    = 3'h1,
      DTE_POS_P    = 3'h2,
      DTE_POS_M    = 3'h3,
      DTE_POS_F    = 3'h4,
      DTE_POS_C    = 3'h5,
      DTE_POS_CPAR = 3'h6,
      DTE_POS_FEBE = 3'h7
   } dte_pos_t;

   typedef struct packed {
      logic     sof;
      dte_pos_t pos;
      logic     data;
   } dte_sym_t;

endpackage

//--- hw/dte_err_arm.sv
// per-type error arming: single pending request and per-frame arm
module dte_err_arm (
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // control
   input  wire logic enable,
   input  wire logic continuous,
   input  wire logic trigger,
   input  wire logic frame_start,
   // state
   output logic      pending,
   output logic      armed
);
   logic pend_ff;
   logic arm_ff;
   logic nxt_pend;
   logic nxt_arm;

   // one pending, consumed at frame start
   // a trigger on the frame start goes straight into the arm
   always_comb begin
      nxt_pend = pend_ff;
      nxt_arm  = arm_ff;
      if (!enable) begin
         nxt_pend = 1'b0;
      end else if (frame_start) begin
         nxt_pend = 1'b0;
      end else if (trigger && !continuous) begin
         nxt_pend = 1'b1;
      end
      if (frame_start) begin
         nxt_arm = enable && (continuous || pend_ff || trigger);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_ff <= 1'b0;
         arm_ff  <= 1'b0;
      end else begin
         pend_ff <= nxt_pend;
         arm_ff  <= nxt_arm;
      end
   end

   assign pending = pend_ff;
   // clearing the enable stops an error already under way
   assign armed   = arm_ff && enable;
endmodule

//--- verification/dte_up_src.sv
// upstream bit source: one short synthetic m-frame per request
module dte_up_src
   import dte_pkg::*;
(
   // clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // request from the bench
   input  wire logic         go,
   output logic              busy,
   // stream toward the block
   output logic              in_valid,
   output dte_pkg::dte_sym_t in_sym
);
   // position classes of one frame, in line order
   localparam dte_pos_t LAYOUT [12] = '{
      DTE_POS_X, DTE_POS_PAY, DTE_POS_F, DTE_POS_PAY, DTE_POS_M,
      DTE_POS_PAY, DTE_POS_F, DTE_POS_PAY, DTE_POS_P, DTE_POS_C,
      DTE_POS_CPAR, DTE_POS_FEBE};
   logic [3:0] cnt_ff;

   assign busy = in_valid | (cnt_ff != 4'h0);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_ff   <= 4'h0;
         in_valid <= 1'b0;
         in_sym   <= '0;
      end else if (go || cnt_ff != 4'h0) begin
         in_valid    <= 1'b1;
         in_sym.sof  <= (cnt_ff == 4'h0);
         in_sym.pos  <= LAYOUT[cnt_ff];
         in_sym.data <= 1'b1;
         cnt_ff      <= (cnt_ff == 4'hb) ? 4'h0 : cnt_ff + 4'h1;
      end else begin
         in_valid    <= 1'b0;
         in_sym.sof  <= 1'b0;
         // stale bit keeps moving so it never looks valid
         in_sym.data <= ~in_sym.data;
      end
   end
endmodule

//--- verification/tb_top.sv
// self-checking bench for the ds3 transmit overhead and error block
module tb_top
   import dte_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {
      logic [15:0] tcr;
      logic        mode;
      logic        alarm;
      logic        rxe;
      logic [11:0] expv;
   } dte_row_t;
   typedef struct {
      logic [15:0] teir;
      logic [11:0] mask;
      logic        cont;
   } dte_err_t;
   logic        pclk = 1'b0;
   logic        presetn;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [13:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd_v;
   logic [3:0]  pstrb = 4'hf;
   logic        pready, pslverr, err_v, out_valid, in_valid, busy;
   logic        go = 1'b0, rx_cpar_err = 1'b0, rx_alarm = 1'b0;
   logic        ext_in = 1'b0, rx_frm_err = 1'b0;
   logic [11:0] got;
   logic [7:0]  pay, x;
   dte_sym_t    in_sym, out_sym;
   int          num_errors = 0, samples_checked = 0, oi = 0;
   // expected frames with all-ones input, bit i is frame position i
   dte_row_t rows [11] = '{
      '{16'h0000, 1'b0, 1'b0, 1'b0, 12'h0af},
      '{16'h0400, 1'b0, 1'b0, 1'b0, 12'heaf},
      '{16'h000c, 1'b0, 1'b0, 1'b0, 12'h0ae},
      '{16'h0004, 1'b0, 1'b1, 1'b0, 12'h0af},
      '{16'h0000, 1'b0, 1'b1, 1'b0, 12'h0ae},
      '{16'h0030, 1'b1, 1'b0, 1'b0, 12'h2af},
      '{16'h0010, 1'b1, 1'b0, 1'b0, 12'haaf},
      '{16'h0000, 1'b1, 1'b0, 1'b1, 12'h2af},
      '{16'h0000, 1'b1, 1'b0, 1'b0, 12'haaf},
      '{16'h1002, 1'b0, 1'b0, 1'b0, 12'heff},
      '{16'h0002, 1'b0, 1'b0, 1'b0, 12'hfff}
   };
   dte_err_t errs [11] = '{
      '{16'h0004, 12'h004, 1'b0}, // f-bit
      '{16'h000c, 12'h010, 1'b0}, // m-bit
      '{16'h0014, 12'h044, 1'b0}, // sef
      '{16'h001c, 12'h010, 1'b0}, // oomf
      '{16'h0018, 12'h000, 1'b0}, // disabled
      '{16'h0020, 12'h100, 1'b0}, // single
      '{16'h0060, 12'h100, 1'b1}, // continuous
      '{16'h0400, 12'h400, 1'b0}, // single
      '{16'h0c00, 12'h400, 1'b1}, // continuous
      '{16'h0100, 12'h800, 1'b0}, // single
      '{16'h0300, 12'h800, 1'b1}  // continuous
   };

   always #25 pclk = ~pclk;

   dte_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .in_valid(in_valid), .in_sym(in_sym), .out_valid(out_valid),
      .out_sym(out_sym), .rx_cpar_err(rx_cpar_err), .rx_frm_err(rx_frm_err),
      .rx_alarm(rx_alarm), .ext_err_insert_input(ext_in));
   dte_up_src src (.pclk(pclk), .presetn(presetn), .go(go), .busy(busy),
      .in_valid(in_valid), .in_sym(in_sym));

   always @(posedge pclk)
      if (out_valid === 1'b1) begin
         if (out_sym.sof === 1'b1)
            oi = 0;
         if (oi < 12)
            got[oi] <= out_sym.data;
         oi++;
      end

   task automatic end_sim();
      if (num_errors == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk_reg(string nm, logic [32:0] e, logic [32:0] g);
      samples_checked++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_frm(string nm, logic [11:0] e, logic [11:0] g);
      samples_checked++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic apb(logic w, logic [11:0] ix, logic [15:0] d,
      logic [3:0] s);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= {ix, 2'b00};
      pwdata  <= {16'h0000, d};
      pstrb   <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         num_errors++;
         end_sim();
      end
      rd_v = prdata;
      err_v = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(logic [11:0] ix, logic [15:0] d);
      apb(1'b1, ix, d, 4'hf);
   endtask

   task automatic rdchk(string nm, logic [11:0] ix, logic [32:0] e);
      apb(1'b0, ix, 16'h0000, 4'hf);
      chk_reg(nm, e, {err_v, rd_v});
   endtask

   // one frame; rx error pulses on its second bit if asked
   task automatic frame(logic rxe, logic frm = 1'b0);
      int n;
      n = 0;
      @(posedge pclk);
      got <= 'x;
      go  <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      // a pulse on the sof bit counts for the frame before
      @(posedge pclk);
      rx_cpar_err <= rxe;
      rx_frm_err  <= frm;
      @(posedge pclk);
      rx_cpar_err <= 1'b0;
      rx_frm_err  <= 1'b0;
      do begin
         @(posedge pclk);
         n++;
      end while (busy !== 1'b0 && n < 40);
      if (busy !== 1'b0) begin
         num_errors++;
         end_sim();
      end
      @(posedge pclk);
   endtask

   initial begin
      presetn = 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      foreach (rows[i]) begin
         wr(DTE_TCR_IDX, rows[i].tcr);
         wr(DTE_MODE_IDX, {15'h0000, rows[i].mode});
         rx_alarm <= rows[i].alarm;
         frame(rows[i].rxe);
         frame(1'b0);
         chk_frm("frame", rows[i].expv, got);
      end
      // framing errors feed automatic febe too
      wr(DTE_TCR_IDX, 16'h0000);
      wr(DTE_MODE_IDX, 16'h0001);
      frame(1'b0, 1'b1);
      frame(1'b0);
      chk_frm("febe frm", 12'h2af, got);
      // payload patterns: alarm alternates, idle changes every two bits
      for (int d = 1; d < 3; d++) begin
         wr(DTE_TCR_IDX, (d == 1) ? 16'h0003 : 16'h0802);
         frame(1'b0);
         pay[3:0] = {got[7], got[5], got[3], got[1]};
         frame(1'b0);
         pay[7:4] = {got[7], got[5], got[3], got[1]};
         x = (pay ^ (pay >> d)) | (8'hff << (8 - d));
         chk_frm("payload", 12'hfff, {4'hf, x});
      end
      // error insertion over a transparent frame
      wr(DTE_TCR_IDX, 16'h0002);
      wr(DTE_MODE_IDX, 16'h0001);
      foreach (errs[i]) begin
         wr(DTE_TEIR_IDX, errs[i].teir);
         if (!errs[i].cont) begin
            wr(DTE_TEIR_IDX, errs[i].teir | 16'h0002);
            wr(DTE_TEIR_IDX, errs[i].teir);
            wr(DTE_TEIR_IDX, errs[i].teir | 16'h0002);
         end
         frame(1'b0);
         chk_frm("err", 12'hfff ^ errs[i].mask, got);
         frame(1'b0);
         chk_frm("err next", errs[i].cont ? 12'hfff ^ errs[i].mask
            : 12'hfff, got);
         wr(DTE_TEIR_IDX, 16'h0000);
         frame(1'b0);
         chk_frm("err off", 12'hfff, got);
      end
      // source switched only while both triggers are low
      wr(DTE_TEIR_IDX, 16'h0005);
      wr(DTE_TEIR_IDX, 16'h0007);
      frame(1'b0);
      chk_frm("reg trig ignored", 12'hfff, got);
      @(posedge pclk);
      ext_in <= 1'b1;
      repeat (8) @(posedge pclk);
      ext_in <= 1'b0;
      frame(1'b0);
      chk_frm("ext trig", 12'hffb, got);
      frame(1'b0);
      chk_frm("ext consumed", 12'hfff, got);
      wr(DTE_TCR_IDX, 16'hffff);
      rdchk("tcr", DTE_TCR_IDX, {17'h0_0000, DTE_TCR_MASK});
      apb(1'b1, DTE_TCR_IDX, 16'h0000, 4'h2);
      rdchk("tcr strb", DTE_TCR_IDX, {17'h0_0000, 16'h003f});
      wr(DTE_TEIR_IDX, 16'hffff);
      rdchk("teir", DTE_TEIR_IDX, {17'h0_0000, DTE_TEIR_MASK});
      wr(DTE_RSV0_IDX, 16'hffff);
      rdchk("reserved", DTE_RSV0_IDX, 33'h0_0000_0000);
      rdchk("unmapped", 12'h000, 33'h1_0000_0000);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rdchk("tcr rst", DTE_TCR_IDX, 33'h0_0000_0000);
      rdchk("teir rst", DTE_TEIR_IDX, 33'h0_0000_0000);
      rdchk("mode rst", DTE_MODE_IDX, 33'h0_0000_0000);
      end_sim();
   end
endmodule
